/* hdl/lgp_pkg.sv */
package lgp_pkg;

  // Channel count and field widths.
  localparam int NUM_CH = 16;
  localparam int PWM_W = 12;
  localparam int TRIM_W = 6;

  // Counter limits and start value, values after reset, and the full trim code.
  localparam logic [PWM_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [PWM_W-1:0] CNT_ONE = 12'h001;
  localparam logic [PWM_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [TRIM_W-1:0] TRIM_ZERO = 6'h00;
  localparam logic [TRIM_W-1:0] TRIM_FULL = 6'h3F;

  // One channel's latched brightness data.
  typedef struct packed {
    logic [PWM_W-1:0] pwm_level;
    logic [TRIM_W-1:0] current_trim_code;
  } lgp_chan_cfg_t;

  localparam lgp_chan_cfg_t CFG_RST = '{pwm_level: 12'h000,
                                         current_trim_code: 6'h00};

  // Display period sequencer states.
  typedef enum logic [2:0] {
    LGP_ST_BLANK = 3'b001,
    LGP_ST_RUN = 3'b010,
    LGP_ST_DONE = 3'b100
  } lgp_state_t;

endpackage

/* hdl/lgp_channel.sv */
`timescale 1ns/10ps
module lgp_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Latch load from the data interface
  input wire logic latch_load_i,
  input wire lgp_pkg::lgp_chan_cfg_t cfg_i,
  // Shared counter state
  input wire logic [lgp_pkg::PWM_W-1:0] cnt_i,
  input wire logic run_i,
  // Sink drive and latched data
  output logic sink_on_o,
  output logic [lgp_pkg::TRIM_W-1:0] trim_o,
  output lgp_pkg::lgp_chan_cfg_t lat_o
);

  lgp_pkg::lgp_chan_cfg_t lat_r;
  lgp_pkg::lgp_chan_cfg_t lat_nxt;
  logic on_r;
  logic on_nxt;
  logic [lgp_pkg::TRIM_W-1:0] trim_r;
  logic [lgp_pkg::TRIM_W-1:0] trim_nxt;

  // New data acts at once, so the controller must load only while blanked.
  always_comb begin
    lat_nxt = latch_load_i ? cfg_i : lat_r;
    on_nxt = run_i && (cnt_i != lgp_pkg::CNT_ZERO) &&
             (cnt_i <= lat_nxt.pwm_level);
    // The analog sink scales full scale by code/63; zero code sinks nothing.
    trim_nxt = on_nxt ? lat_nxt.current_trim_code : lgp_pkg::TRIM_ZERO;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_r <= lgp_pkg::CFG_RST;
      on_r <= 1'b0;
      trim_r <= lgp_pkg::TRIM_ZERO;
    end else begin
      lat_r <= lat_nxt;
      on_r <= on_nxt;
      trim_r <= trim_nxt;
    end
  end

  assign sink_on_o = on_r;
  assign trim_o = trim_r;
  assign lat_o = lat_r;

  a_latch_load: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    latch_load_i |=> (lat_r == $past(cfg_i)))
    else $error("Latch did not take loaded data.");

  a_latch_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !latch_load_i |=> $stable(lat_r))
    else $error("Latch changed without a load.");

endmodule

/* hdl/lgp_top.sv */
`timescale 1ns/10ps
module lgp_top #(
  parameter int NUM_CH = lgp_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Display controller pins
  input wire logic pwm_ref_clock_i,
  input wire logic blank_i,
  // Latch load from the data interface
  input wire logic latch_load_i,
  input wire lgp_pkg::lgp_chan_cfg_t [NUM_CH-1:0] chan_cfg_i,
  // Sink drive
  output logic [NUM_CH-1:0] sink_outputs_o,
  output logic [NUM_CH-1:0][lgp_pkg::TRIM_W-1:0] current_trim_code_o
);

  // Pin synchronisers.
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_s3_r;
  logic blank_s1_r;
  logic blank_s2_r;
  logic ref_rise;

  // Shared counter and sequencer.
  lgp_pkg::lgp_state_t state_r;
  lgp_pkg::lgp_state_t state_nxt;
  logic [lgp_pkg::PWM_W-1:0] cnt_r;
  logic [lgp_pkg::PWM_W-1:0] cnt_nxt;
  logic run;

  // Latched data seen by the checks.
  lgp_pkg::lgp_chan_cfg_t [NUM_CH-1:0] lat;

  // Both pins pass the same depth, so an edge and a blanking change that
  // arrive together are still seen in their true order.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      blank_s1_r <= 1'b1;
      blank_s2_r <= 1'b1;
    end else begin
      ref_s1_r <= pwm_ref_clock_i;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      blank_s1_r <= blank_i;
      blank_s2_r <= blank_s1_r;
    end
  end

  // The reference clock must stay below half the system clock rate.
  assign ref_rise = ref_s2_r && !ref_s3_r;

  // After the last count the period ends and no output turns on again
  // until blanking has been raised and dropped.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (blank_s2_r) begin
      state_nxt = lgp_pkg::LGP_ST_BLANK;
      cnt_nxt = lgp_pkg::CNT_ZERO;
    end else begin
      case (state_r)
        lgp_pkg::LGP_ST_BLANK: begin
          if (ref_rise) begin
            state_nxt = lgp_pkg::LGP_ST_RUN;
            cnt_nxt = lgp_pkg::CNT_ONE;
          end
        end
        lgp_pkg::LGP_ST_RUN: begin
          if (ref_rise) begin
            if (cnt_r == lgp_pkg::CNT_MAX) begin
              state_nxt = lgp_pkg::LGP_ST_DONE;
            end else begin
              cnt_nxt = cnt_r + lgp_pkg::CNT_ONE;
            end
          end
        end
        lgp_pkg::LGP_ST_DONE: begin
          cnt_nxt = cnt_r;
        end
        default: begin
          state_nxt = lgp_pkg::LGP_ST_BLANK;
          cnt_nxt = lgp_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= lgp_pkg::LGP_ST_BLANK;
      cnt_r <= lgp_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign run = (state_r == lgp_pkg::LGP_ST_RUN) && !blank_s2_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      lgp_channel u_ch (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .latch_load_i(latch_load_i),
        .cfg_i(chan_cfg_i[gi]),
        .cnt_i(cnt_r),
        .run_i(run),
        .sink_on_o(sink_outputs_o[gi]),
        .trim_o(current_trim_code_o[gi]),
        .lat_o(lat[gi])
      );

      a_zero_off: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (lat[gi].pwm_level == lgp_pkg::CNT_ZERO) |-> !sink_outputs_o[gi])
        else $error("Channel with zero level is on.");

      a_first_on: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_r == lgp_pkg::LGP_ST_RUN && cnt_r == lgp_pkg::CNT_ONE &&
         !blank_s2_r && !latch_load_i &&
         lat[gi].pwm_level != lgp_pkg::CNT_ZERO) |=> sink_outputs_o[gi])
        else $error("Nonzero channel missed the first count.");

      a_on_window: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        sink_outputs_o[gi] |->
          ($past(cnt_r) <= lat[gi].pwm_level &&
           $past(cnt_r) != lgp_pkg::CNT_ZERO))
        else $error("Channel on outside its count window.");

      a_blank_off: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        blank_s2_r |=> (!sink_outputs_o[gi] &&
                        current_trim_code_o[gi] == lgp_pkg::TRIM_ZERO))
        else $error("Output driven while blanked.");

      a_trim_level: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        current_trim_code_o[gi] == (sink_outputs_o[gi] ?
          lat[gi].current_trim_code : lgp_pkg::TRIM_ZERO))
        else $error("Trim code does not follow the channel state.");

      // A load in the same cycle moves the level, so it is left out here.
      a_on_due: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (run && cnt_r != lgp_pkg::CNT_ZERO && !latch_load_i &&
         cnt_r <= lat[gi].pwm_level) |=> sink_outputs_o[gi])
        else $error("Channel off inside its count window.");

      a_off_past: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (cnt_r > lat[gi].pwm_level && !latch_load_i) |=>
          !sink_outputs_o[gi])
        else $error("Channel still on past its level.");
    end
  endgenerate

  a_cnt_step: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (ref_rise && !blank_s2_r && state_r == lgp_pkg::LGP_ST_RUN &&
     cnt_r != lgp_pkg::CNT_MAX) |=> (cnt_r == $past(cnt_r) + 12'h001))
    else $error("Counter did not step on a reference edge.");

  a_cnt_still: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (!ref_rise && !blank_s2_r) |=> $stable(cnt_r))
    else $error("Counter moved without a reference edge.");

  a_blank_clear: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    blank_s2_r |=> (cnt_r == lgp_pkg::CNT_ZERO))
    else $error("Counter not held at zero while blanked.");

  a_resume: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == lgp_pkg::LGP_ST_BLANK && !blank_s2_r && ref_rise) |=>
      (cnt_r == lgp_pkg::CNT_ONE && state_r == lgp_pkg::LGP_ST_RUN))
    else $error("Counter did not resume after blanking.");

  // Outputs lag the counter by one edge, so the last on cycle of a full
  // level channel overlaps the first cycle of the ended period.
  a_end_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == lgp_pkg::LGP_ST_DONE && !blank_s2_r) |=>
      (sink_outputs_o == '0))
    else $error("Output on after the period ended.");

  a_done_stay: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == lgp_pkg::LGP_ST_DONE && !blank_s2_r) |=>
      (state_r == lgp_pkg::LGP_ST_DONE && cnt_r == lgp_pkg::CNT_MAX))
    else $error("Ended period did not hold its final count.");

  a_blank_state: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    blank_s2_r |=> (state_r == lgp_pkg::LGP_ST_BLANK))
    else $error("Sequencer left blanking while blanked.");

  a_run_gate: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !run |=> (sink_outputs_o == '0))
    else $error("Output on while the counter is not running.");

  a_state_valid: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $onehot(state_r))
    else $error("Sequencer state is not one-hot.");

endmodule

/* dv/lgp_ctrl_model.sv */
`timescale 1ns/10ps
module lgp_ctrl_model (
  // Clock
  input wire logic sys_clk_i,
  // Controller pins
  output logic pwm_ref_clock_o,
  output logic blank_o
);
  // Blanking is high from power-up, so nothing lights before data load.
  initial begin
    blank_o = 1'b1;
    pwm_ref_clock_o = 1'b0;
  end

  // Two cycles high and two low, four system cycles per reference edge.
  task automatic ref_pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1 pwm_ref_clock_o = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1 pwm_ref_clock_o = 1'b0;
      @(posedge sys_clk_i);
    end
  endtask

  task automatic set_blank(input logic b);
    @(posedge sys_clk_i);
    #1 blank_o = b;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic latch_load_i = 1'b0;
  logic pwm_ref_clock_i;
  logic blank_i;
  lgp_pkg::lgp_chan_cfg_t [15:0] cfg = '0;
  logic [15:0] sink_o;
  logic [15:0][5:0] trim_o;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  lgp_ctrl_model ctrl (.sys_clk_i(sys_clk_i),
    .pwm_ref_clock_o(pwm_ref_clock_i), .blank_o(blank_i));

  lgp_top #(.NUM_CH(16)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .pwm_ref_clock_i(pwm_ref_clock_i), .blank_i(blank_i),
    .latch_load_i(latch_load_i), .chan_cfg_i(cfg),
    .sink_outputs_o(sink_o), .current_trim_code_o(trim_o));

  // Outputs expected after k reference edges of the current period.
  function automatic logic [15:0] exp_on(input int k);
    for (int i = 0; i < 16; i++) begin
      exp_on[i] = k >= 1 && cfg[i].pwm_level != 12'h000 &&
                  k <= int'(cfg[i].pwm_level);
    end
  endfunction

  function automatic logic [15:0][5:0] exp_trim(input logic [15:0] on);
    for (int i = 0; i < 16; i++) begin
      exp_trim[i] = on[i] ? cfg[i].current_trim_code : 6'h00;
    end
  endfunction

  // Load is made only while blanked, so no glitch reaches the sinks.
  task automatic load(input int trim_base);
    @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 16; i++) begin
      cfg[i].pwm_level = (i == 15) ? 12'hFFF : 12'(i);
      cfg[i].current_trim_code = 6'(i * 4 + trim_base);
    end
    latch_load_i = 1'b1;
    @(posedge sys_clk_i);
    #1 latch_load_i = 1'b0;
  endtask

  task automatic pulse_check(input int n, input int k);
    ctrl.ref_pulses(n);
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(sink_o, exp_on(k))
    `CHK(trim_o, exp_trim(exp_on(k)))
  endtask

  task automatic t_blanked();
    load(3);
    ctrl.ref_pulses(3);
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK(sink_o, 16'h0000)
    `CHK(trim_o, '0)
  endtask

  task automatic t_period();
    ctrl.set_blank(1'b0);
    #1;
    `CHK(sink_o, 16'h0000)
    for (int k = 1; k <= 17; k++) begin
      pulse_check(1, k);
    end
    pulse_check(4095 - 17, 4095);
    pulse_check(1, 4096);
  endtask

  task automatic t_reblank();
    ctrl.set_blank(1'b1);
    #1;
    `CHK(sink_o, 16'h0000)
    load(0);
    ctrl.set_blank(1'b0);
    pulse_check(1, 1);
    pulse_check(1, 2);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The longest period takes about 16500 cycles; this leaves ample room.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    t_blanked();
    t_period();
    t_reblank();
    end_sim();
  end
endmodule
